// ==== src/fdl_pkg.sv ====
// Purpose: Shared constants and types for the data link send and legacy receive block
// Assumes: Wishbone word per register, byte address is four times the register index
// Notes: Only the low byte of each word carries data
//
// Functional notes
// [R1] Trigger rising edge sends code once
// [R2] Source select: pin or packet controller
// [R3] Code sent bit 0 first, bit 5 last
// [R4] FIFO register write pushes one packet byte
// [R5] Only one transmit source drives at once
// [R6] Packet path and legacy path share receive
// [R7] Received bits shift into eight bit register
// [R8] Full byte sets full flag, maskable interrupt
// [R9] Host reads each byte before next fills
// [R10] Byte matching either match byte sets flag
// [R11] Destuff drops zero after exactly five ones
// [R12] Zero after six or more ones kept
// [R13] Host should keep destuffing enabled
// [R14] First received bit lands in bit zero
// [R15] Match bytes at indexes 29h and 2Ah
// [R16] Match checked only on complete bytes
package fdl_pkg;

   // ***************************************************
   // Register indexes (byte address = index * 4)
   // ***************************************************
   localparam logic [7:0] IDX_CODE = 8'h07;   // Send code control
   localparam logic [7:0] IDX_FIFO = 8'h08;   // Packet transmit FIFO data
   localparam logic [7:0] IDX_RXBYTE = 8'h28; // Legacy receive byte
   localparam logic [7:0] IDX_M1 = 8'h29;     // Match byte one
   localparam logic [7:0] IDX_M2 = 8'h2a;     // Match byte two
   localparam logic [7:0] IDX_STAT = 8'h30;   // Sticky status, write one to clear
   localparam logic [7:0] IDX_MASK = 8'h31;   // Interrupt mask, same layout
   localparam logic [7:0] IDX_CTRL = 8'h32;   // Receive control

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int TRIG_BIT = 7;        // Send code trigger
   localparam int SEL_BIT = 6;         // Link source select
   localparam int CODE_W = 6;          // Code width
   localparam int STAT_MATCH = 2;      // Match flag and mask
   localparam int STAT_FULL = 4;       // Buffer full flag and mask
   localparam int CTRL_DESTUFF = 0;    // Destuff enable
   localparam int CTRL_FS = 1;         // Receive from framing signal bits
   localparam logic [7:0] STAT_USED = 8'h14; // Implemented status bits

   // ***************************************************
   // Reset values and counts
   // ***************************************************
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam logic [7:0] MATCH_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] CODE_LAST = 3'h5;  // Index of last code bit
   localparam logic [2:0] BYTE_LAST = 3'h7;  // Index of last byte bit
   localparam logic [2:0] STUFF_RUN = 3'h5;  // Ones before a stuffed zero

   // Code sender states
   typedef enum logic {
      CS_IDLE = 1'b0,
      CS_SEND = 1'b1
   } fdl_code_st_t;

endpackage : fdl_pkg

// ==== src/fdl_destuff.sv ====
// Purpose: Zero destuffer for the legacy receive bit stream
// Assumes: One bit per valid strobe
// Notes: Output is registered, one cycle behind the input
`timescale 1ns/1ps
module fdl_destuff
   import fdl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,    // Destuff enable
   input wire logic bit_i,   // Incoming bit
   input wire logic valid_i, // Incoming bit strobe
   output logic bit_o,       // Passed bit
   output logic valid_o      // Passed bit strobe
);

   typedef struct packed {
      logic b;          // Held bit
      logic v;          // Held strobe
      logic [2:0] ones; // Consecutive ones, saturating
   } fdl_dst_t;

   fdl_dst_t st_q;
   fdl_dst_t st_d;

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      st_d = st_q;
      st_d.v = 1'b0;
      if (valid_i) begin
         st_d.b = bit_i;
         st_d.v = 1'b1;
         if (bit_i) begin
            // Count ones, stop at seven
            if (st_q.ones != 3'h7) begin
               st_d.ones = st_q.ones + 3'h1;
            end
         end else begin
            // Drop zero after exactly five ones
            if (en_i && st_q.ones == STUFF_RUN) begin // see [R11] [R12]
               st_d.v = 1'b0;
            end
            st_d.ones = 3'h0;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign bit_o = st_q.b;
   assign valid_o = st_q.v;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_drop_stuffed;
      en_i && valid_i && !bit_i && st_q.ones == STUFF_RUN |=> !valid_o;
   endproperty
   a_drop_stuffed: assert property (p_drop_stuffed) else $error("Stuffed zero passed"); // see [R11]

   property p_keep_long_run;
      valid_i && !bit_i && st_q.ones > STUFF_RUN |=> valid_o && !bit_o;
   endproperty
   a_keep_long_run: assert property (p_keep_long_run) else $error("Zero after long run lost"); // see [R12]

   c_drop: cover property (en_i && valid_i && !bit_i && st_q.ones == STUFF_RUN);

endmodule : fdl_destuff

// ==== src/fdl_link_top.sv ====
// Purpose: Data link code sender, source select, FIFO write port, legacy receive
// Assumes: Frame stream strobes are synchronous to clk_i, one cycle wide
// Notes: Wishbone classic slave, one ack per access, data in low byte
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module fdl_link_top
   import fdl_pkg::*;
#(
   parameter int AW = 10 // Byte address width
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [AW-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Transmit side
   input wire logic link_data_input_pin_i, // External link data
   input wire logic pkt_bit_i,             // Packet controller bit
   input wire logic tx_strobe_i,           // Frame takes one link bit
   output logic tx_link_o,                 // Selected link bit
   output logic pkt_take_o,                // Packet controller bit consumed
   output logic fifo_wr_o,                 // Packet FIFO push
   output logic [7:0] fifo_data_o,         // Packet FIFO byte
   // Receive side
   input wire logic rx_link_bit_i,         // Recovered link bit
   input wire logic framing_signal_bits_i, // Recovered framing signal bit
   input wire logic rx_valid_i,            // Receive bit strobe
   output logic pkt_rx_bit_o,              // Link bit to packet controller
   output logic pkt_rx_valid_o,            // Its strobe
   // Interrupt
   output logic irq_n_o                    // Active low level
);

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic ack;              // Bus answer
      logic [7:0] dat;        // Read data
      logic [7:0] code_ctl;   // Send code control
      logic [7:0] m1;         // Match byte one
      logic [7:0] m2;         // Match byte two
      logic [7:0] stat;       // Sticky status
      logic [7:0] mask;       // Interrupt mask
      logic [7:0] ctrl;       // Receive control
      logic [7:0] shreg;      // Receive shifter
      logic [2:0] bitcnt;     // Bits in shifter
      logic [7:0] rxbyte;     // Completed byte
      fdl_code_st_t cst;      // Code sender state
      logic [5:0] code_sh;    // Code bits left
      logic [2:0] code_cnt;   // Code bits sent
      logic tx_bit;           // Link out
      logic pkt_take;         // Packet bit consumed
      logic fifo_wr;          // FIFO push
      logic [7:0] fifo_data;  // FIFO byte
      logic irq_n;            // Interrupt out
      logic pkt_rx_bit;       // Packet receive bit
      logic pkt_rx_valid;     // Packet receive strobe
   } fdl_state_t;

   fdl_state_t st_q;
   fdl_state_t st_d;

   logic [7:0] idx;        // Register index
   logic req;              // New bus request
   logic wr_go;            // Write at ack edge
   logic wr_code;          // Write to send code control
   logic trig_rise;        // Trigger written 0 to 1
   logic raw_bit;          // Selected receive bit
   logic dst_bit;          // Destuffed bit
   logic dst_valid;        // Destuffed strobe
   logic [7:0] new_byte;   // Shifter after this bit
   logic byte_done;        // Last bit of a byte
   logic is_match;         // Completed byte matches

   // ***************************************************
   // Decode
   // ***************************************************
   assign idx = adr_i[AW-1:2];
   // New request only while no ack stands
   assign req = cyc_i && stb_i && !st_q.ack;
   // Writes land on the edge the master sees ack
   assign wr_go = cyc_i && stb_i && we_i && st_q.ack && sel_i[0];
   assign wr_code = wr_go && idx == IDX_CODE;
   // Edge taken against the stored bit, so a held one is ignored
   assign trig_rise = wr_code && dat_i[TRIG_BIT] && !st_q.code_ctl[TRIG_BIT]; // see [R1]

   // Receive bit source, legacy path only
   assign raw_bit = st_q.ctrl[CTRL_FS] ? framing_signal_bits_i : rx_link_bit_i; // see [R7]
   assign new_byte = {dst_bit, st_q.shreg[7:1]}; // see [R14]
   assign byte_done = dst_valid && st_q.bitcnt == BYTE_LAST; // see [R16]
   assign is_match = new_byte == st_q.m1 || new_byte == st_q.m2; // see [R10] [R15]

   // ***************************************************
   // Destuffer
   // ***************************************************
   fdl_destuff u_destuff (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(st_q.ctrl[CTRL_DESTUFF]),
      .bit_i(raw_bit),
      .valid_i(rx_valid_i),
      .bit_o(dst_bit),
      .valid_o(dst_valid)
   );

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      st_d = st_q;
      st_d.ack = 1'b0;
      st_d.fifo_wr = 1'b0;
      st_d.pkt_take = 1'b0;

      // Bus answer and read mux
      if (req) begin
         st_d.ack = 1'b1;
         case (idx)
            IDX_CODE: st_d.dat = st_q.code_ctl;
            IDX_RXBYTE: st_d.dat = st_q.rxbyte; // see [R14]
            IDX_M1: st_d.dat = st_q.m1;
            IDX_M2: st_d.dat = st_q.m2;
            IDX_STAT: st_d.dat = st_q.stat;
            IDX_MASK: st_d.dat = st_q.mask;
            IDX_CTRL: st_d.dat = st_q.ctrl;
            default: st_d.dat = 8'h00; // Unmapped and write-only
         endcase
      end

      // Register writes
      if (wr_go) begin
         case (idx)
            IDX_CODE: st_d.code_ctl = dat_i[7:0];
            IDX_FIFO: begin
               // Push byte, bit 7 is MSB
               st_d.fifo_wr = 1'b1; // see [R4]
               st_d.fifo_data = dat_i[7:0];
            end
            IDX_M1: st_d.m1 = dat_i[7:0]; // see [R15]
            IDX_M2: st_d.m2 = dat_i[7:0];
            IDX_STAT: st_d.stat = st_q.stat & ~dat_i[7:0];
            IDX_MASK: st_d.mask = dat_i[7:0] & STAT_USED;
            IDX_CTRL: st_d.ctrl = dat_i[7:0] & 8'h03;
            default: ;
         endcase
      end

      // Code sender
      case (st_q.cst)
         CS_IDLE: begin
            if (trig_rise) begin // see [R1]
               st_d.cst = CS_SEND;
               st_d.code_sh = dat_i[CODE_W-1:0]; // see [R3]
               st_d.code_cnt = 3'h0;
            end
         end
         CS_SEND: begin
            if (trig_rise) begin
               // Fresh edge restarts the code
               st_d.code_sh = dat_i[CODE_W-1:0];
               st_d.code_cnt = 3'h0;
            end else if (tx_strobe_i && st_q.code_ctl[SEL_BIT]) begin
               // Bit 0 leaves first
               st_d.code_sh = {1'b0, st_q.code_sh[5:1]}; // see [R3]
               st_d.code_cnt = st_q.code_cnt + 3'h1;
               if (st_q.code_cnt == CODE_LAST) begin
                  st_d.cst = CS_IDLE;
               end
            end
         end
         default: st_d.cst = CS_IDLE;
      endcase

      // Single source for the link bit
      if (!st_q.code_ctl[SEL_BIT]) begin
         st_d.tx_bit = link_data_input_pin_i; // see [R2]
      end else if (st_q.cst == CS_SEND) begin
         st_d.tx_bit = st_q.code_sh[0]; // see [R1] [R5]
      end else begin
         st_d.tx_bit = pkt_bit_i; // see [R2] [R5]
         st_d.pkt_take = tx_strobe_i;
      end

      // Packet controller sees every raw link bit
      st_d.pkt_rx_bit = rx_link_bit_i; // see [R6]
      st_d.pkt_rx_valid = rx_valid_i;

      // Legacy shifter, first bit ends in bit 0
      if (dst_valid) begin
         st_d.shreg = new_byte; // see [R7]
         st_d.bitcnt = st_q.bitcnt + 3'h1;
         if (byte_done) begin
            // Old byte is overwritten if unread
            st_d.rxbyte = new_byte; // see [R9]
            st_d.stat[STAT_FULL] = 1'b1; // see [R8]
            if (is_match) begin
               st_d.stat[STAT_MATCH] = 1'b1; // see [R10]
            end
         end
      end

      // Level interrupt, low while unmasked flag set
      st_d.irq_n = ~|(st_d.stat & st_d.mask); // see [R8] [R10]
   end

   // ***************************************************
   // State register
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
         st_q.code_ctl <= CODE_RST;
         st_q.m1 <= MATCH_RST;
         st_q.m2 <= MATCH_RST;
         st_q.mask <= MASK_RST;
         st_q.ctrl <= CTRL_RST;
         st_q.cst <= CS_IDLE;
         st_q.irq_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   // Every output is a flip-flop of the state
   assign dat_o = {24'h000000, st_q.dat};
   assign ack_o = st_q.ack;
   assign tx_link_o = st_q.tx_bit;
   assign pkt_take_o = st_q.pkt_take;
   assign fifo_wr_o = st_q.fifo_wr;
   assign fifo_data_o = st_q.fifo_data;
   assign pkt_rx_bit_o = st_q.pkt_rx_bit;
   assign pkt_rx_valid_o = st_q.pkt_rx_valid;
   assign irq_n_o = st_q.irq_n;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Trigger edge starts the sender
   property p_trig_start;
      trig_rise |=> st_q.cst == CS_SEND && st_q.code_sh == $past(dat_i[5:0]);
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("Code send not started"); // see [R1]

   // A held trigger starts nothing
   property p_no_retrigger;
      st_q.cst == CS_IDLE && !trig_rise |=> st_q.cst == CS_IDLE;
   endproperty
   a_no_retrigger: assert property (p_no_retrigger) else $error("Code send without edge"); // see [R1]

   // Six strobes finish the code
   property p_code_len;
      trig_rise ##1 (st_q.code_ctl[SEL_BIT] && tx_strobe_i && !trig_rise) [*6] |=> st_q.cst == CS_IDLE;
   endproperty
   a_code_len: assert property (p_code_len) else $error("Code length wrong"); // see [R3]

   // Code bits wait for a strobe
   property p_code_wait;
      st_q.cst == CS_SEND && !(tx_strobe_i && st_q.code_ctl[SEL_BIT]) && !trig_rise |=> $stable(st_q.code_sh);
   endproperty
   a_code_wait: assert property (p_code_wait) else $error("Code bit left without strobe"); // see [R3]

   // Pin source
   property p_src_pin;
      !st_q.code_ctl[SEL_BIT] |=> tx_link_o == $past(link_data_input_pin_i);
   endproperty
   a_src_pin: assert property (p_src_pin) else $error("Pin source not used"); // see [R2]

   // Packet source only when no code pending
   property p_src_pkt;
      st_q.code_ctl[SEL_BIT] && st_q.cst == CS_IDLE |=> tx_link_o == $past(pkt_bit_i);
   endproperty
   a_src_pkt: assert property (p_src_pkt) else $error("Packet source not used"); // see [R2] [R5]

   // Code bit wins over packet bit
   property p_src_code;
      st_q.code_ctl[SEL_BIT] && st_q.cst == CS_SEND |=> tx_link_o == $past(st_q.code_sh[0]) && !pkt_take_o;
   endproperty
   a_src_code: assert property (p_src_code) else $error("Two sources at once"); // see [R5]

   // FIFO push carries the written byte
   property p_fifo_push;
      wr_go && idx == IDX_FIFO |=> fifo_wr_o && fifo_data_o == $past(dat_i[7:0]);
   endproperty
   a_fifo_push: assert property (p_fifo_push) else $error("FIFO byte lost"); // see [R4]

   // Receive bits forwarded untouched
   property p_pkt_rx;
      rx_valid_i |=> pkt_rx_valid_o && pkt_rx_bit_o == $past(rx_link_bit_i);
   endproperty
   a_pkt_rx: assert property (p_pkt_rx) else $error("Packet receive bit lost"); // see [R6]

   // Full byte raises flag and lands
   property p_full;
      byte_done |=> st_q.stat[STAT_FULL] && st_q.rxbyte == $past(new_byte);
   endproperty
   a_full: assert property (p_full) else $error("Full flag missing"); // see [R8] [R14]

   // Whole matching byte sets match flag
   property p_match;
      byte_done && is_match |=> st_q.stat[STAT_MATCH];
   endproperty
   a_match: assert property (p_match) else $error("Match flag missing"); // see [R10]

   // No match flag between bytes
   property p_no_partial_match;
      !byte_done && !st_q.stat[STAT_MATCH] |=> !st_q.stat[STAT_MATCH];
   endproperty
   a_no_partial_match: assert property (p_no_partial_match) else $error("Match flag without byte"); // see [R16]

   // Received byte only moves on a full byte
   property p_rxbyte_hold;
      !byte_done |=> $stable(st_q.rxbyte);
   endproperty
   a_rxbyte_hold: assert property (p_rxbyte_hold) else $error("Receive byte changed early"); // see [R16]

   // Interrupt follows flags and mask
   property p_irq;
      |(st_q.stat & st_q.mask) |-> !irq_n_o;
   endproperty
   a_irq: assert property (p_irq) else $error("Interrupt not raised"); // see [R8]

   // Interrupt released when nothing unmasked
   property p_irq_clear;
      !(|(st_q.stat & st_q.mask)) |-> irq_n_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("Interrupt stuck low"); // see [R8] [R10]

   c_code_done: cover property (st_q.cst == CS_SEND ##1 st_q.cst == CS_IDLE);
   c_match: cover property (byte_done && is_match);
   c_irq: cover property ($fell(irq_n_o));

endmodule : fdl_link_top

// ==== dv/fdl_frame_model.sv ====
// Purpose: Frame stream stand-in facing the link block
// Assumes: Bench clock, lines change just after rising edges
// Notes: Released receive lines show the inverse of the last bit
`timescale 1ns/1ps
module fdl_frame_model (
   input wire logic clk_i,
   output logic link_pin_o,  // External link bit
   output logic pkt_bit_o,   // Packet controller bit
   output logic tx_strobe_o, // Frame takes a link bit
   output logic rx_bit_o,    // Recovered link bit
   output logic fs_bit_o,    // Recovered framing bit
   output logic rx_valid_o   // Receive bit strobe
);
   // ***************************************************
   // Idle levels
   // ***************************************************
   initial begin
      link_pin_o = 1'b0;
      pkt_bit_o = 1'b0;
      tx_strobe_o = 1'b0;
      rx_bit_o = 1'b0;
      fs_bit_o = 1'b0;
      rx_valid_o = 1'b0;
   end

   // ***************************************************
   // Transmit side
   // ***************************************************
   // Set both transmit sources
   task automatic set_src(input logic pin, input logic pkt);
      @(posedge clk_i);
      link_pin_o <= pin;
      pkt_bit_o <= pkt;
      #1;
   endtask : set_src

   // One link bit slot of the frame
   task automatic tx_step();
      @(posedge clk_i);
      tx_strobe_o <= 1'b1;
      @(posedge clk_i);
      tx_strobe_o <= 1'b0;
      #1;
   endtask : tx_step

   // Hold the strobe at a level, back to back slots
   task automatic set_strobe(input logic s);
      @(posedge clk_i);
      tx_strobe_o <= s;
      #1;
   endtask : set_strobe

   // ***************************************************
   // Receive side
   // ***************************************************
   // One recovered bit, one strobe each, lines inverted after
   task automatic rx_bit(input logic lnk, input logic fs);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_bit_o <= lnk;
      fs_bit_o <= fs;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_bit_o <= ~lnk;
      fs_bit_o <= ~fs;
      #1;
   endtask : rx_bit
endmodule : fdl_frame_model

// ==== dv/fdl_link_top_test.sv ====
// Purpose: Self-checking bench for the link send and legacy receive block
// Assumes: Wishbone word per register, data in the low byte
// Notes: Frame stream comes from the frame model
`timescale 1ns/1ps
module fdl_link_top_test;
   import fdl_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
   logic [9:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o;
   logic pin, pkt, strb, tx_link_o, pkt_take_o, fifo_wr_o;
   logic [7:0] fifo_data_o;
   logic rxb, fsb, rxv, pkt_rx_bit_o, pkt_rx_valid_o, irq_n_o;
   logic fs_sel; // Receive from framing bits
   logic [7:0] tmp;
   int n_errors = 0;
   int n_checks = 0;
   logic [5:0] tx_code = 6'h2d; // Code under test
   logic [7:0] ridx [9] = '{IDX_CODE, IDX_FIFO, IDX_RXBYTE, IDX_M1, IDX_M2,
                            IDX_STAT, IDX_MASK, IDX_CTRL, 8'h3f};
   logic [7:0] mt [3] = '{8'h3c, 8'h96, 8'h55};

   fdl_link_top u_fdl_link_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .link_data_input_pin_i(pin), .pkt_bit_i(pkt), .tx_strobe_i(strb), .tx_link_o(tx_link_o),
      .pkt_take_o(pkt_take_o), .fifo_wr_o(fifo_wr_o), .fifo_data_o(fifo_data_o),
      .rx_link_bit_i(rxb), .framing_signal_bits_i(fsb), .rx_valid_i(rxv),
      .pkt_rx_bit_o(pkt_rx_bit_o), .pkt_rx_valid_o(pkt_rx_valid_o), .irq_n_o(irq_n_o));

   fdl_frame_model u_fdl_frame_model (.clk_i(clk_i), .link_pin_o(pin), .pkt_bit_o(pkt),
      .tx_strobe_o(strb), .rx_bit_o(rxb), .fs_bit_o(fsb), .rx_valid_o(rxv));

   // ***************************************************
   // Clock
   // ***************************************************
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // ***************************************************
   // Checks and closing
   // ***************************************************
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   // ***************************************************
   // Wishbone classic master
   // ***************************************************
   task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
      int i;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= wr;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h000000, wd};
      sel_i <= 4'h1;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack_o !== 1'b1 && i < 20);
      rd = dat_o[7:0];
      if (i >= 20) begin
         n_errors++;
         end_of_test();
      end else begin
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i <= 1'b0;
         #1;
      end
   endtask : wb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d, tmp);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      wb(1'b0, idx, 8'h00, v);
      chk_byte(v, exp);
   endtask : rd_chk

   // Send n bits first bit in bit 0, watch the packet receive copy
   task automatic rx_seq(input logic [15:0] v, input int n);
      logic lnk;
      for (int i = 0; i < n; i++) begin
         lnk = fs_sel ? ~v[i] : v[i];
         u_fdl_frame_model.rx_bit(lnk, ~lnk);
         chk_bit(pkt_rx_valid_o, 1'b1);
         chk_bit(pkt_rx_bit_o, lnk);
      end
   endtask : rx_seq

   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask : tick

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 10'h000;
      sel_i = 4'h0;
      dat_i = 32'h00000000;
      fs_sel = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, write-only and unmapped reads
      for (int k = 0; k < 9; k++) begin
         rd_chk(ridx[k], 8'h00);
      end
      chk_bit(irq_n_o, 1'b1);
      wr(IDX_RXBYTE, 8'hff);
      rd_chk(IDX_RXBYTE, 8'h00);
      wr(IDX_MASK, 8'hff);
      rd_chk(IDX_MASK, STAT_USED);
      wr(IDX_CODE, {2'b00, tx_code});
      rd_chk(IDX_CODE, {2'b00, tx_code});
      // FIFO byte push
      wr(IDX_FIFO, 8'ha5);
      chk_bit(fifo_wr_o, 1'b1);
      chk_byte(fifo_data_o, 8'ha5);
      // Pin source while select low, packet source while high
      u_fdl_frame_model.set_src(1'b1, 1'b0);
      tick();
      chk_bit(tx_link_o, 1'b1);
      u_fdl_frame_model.tx_step();
      chk_bit(pkt_take_o, 1'b0);
      wr(IDX_CODE, 8'h40);
      tick();
      chk_bit(tx_link_o, 1'b0);
      u_fdl_frame_model.tx_step();
      chk_bit(pkt_take_o, 1'b1);
      // Code send, bit 0 first, packet bits held off
      wr(IDX_CODE, {2'b11, tx_code});
      repeat (3) tick();
      for (int k = 0; k < 6; k++) begin
         chk_bit(tx_link_o, tx_code[k]);
         u_fdl_frame_model.tx_step();
         chk_bit(pkt_take_o, 1'b0);
         tick();
      end
      chk_bit(tx_link_o, 1'b0);
      u_fdl_frame_model.tx_step();
      chk_bit(pkt_take_o, 1'b1);
      // Held trigger sends nothing, fresh edge sends again
      wr(IDX_CODE, {2'b11, tx_code});
      repeat (3) tick();
      chk_bit(tx_link_o, 1'b0);
      wr(IDX_CODE, {2'b01, tx_code});
      // Back to back strobes through the whole code
      u_fdl_frame_model.set_strobe(1'b1);
      wr(IDX_CODE, {2'b11, tx_code});
      for (int k = 0; k < 6; k++) begin
         tick();
         chk_bit(tx_link_o, tx_code[k]);
      end
      tick();
      chk_bit(tx_link_o, 1'b0);
      chk_bit(pkt_take_o, 1'b1);
      u_fdl_frame_model.set_strobe(1'b0);
      // Full flag only on complete byte
      wr(IDX_MASK, 8'h10);
      rx_seq(16'h004b, 7);
      rd_chk(IDX_STAT, 8'h00);
      rx_seq(16'h0000, 1);
      rd_chk(IDX_STAT, 8'h10);
      chk_bit(irq_n_o, 1'b0);
      rd_chk(IDX_RXBYTE, 8'h4b);
      wr(IDX_STAT, 8'h10);
      rd_chk(IDX_STAT, 8'h00);
      chk_bit(irq_n_o, 1'b1);
      // Both match bytes and a miss, only match masked in
      wr(IDX_M1, 8'h3c);
      wr(IDX_M2, 8'h96);
      wr(IDX_MASK, 8'h04);
      rd_chk(IDX_M2, 8'h96);
      for (int k = 0; k < 3; k++) begin
         rx_seq({8'h00, mt[k]}, 8);
         rd_chk(IDX_STAT, (k < 2) ? 8'h14 : 8'h10);
         chk_bit(irq_n_o, (k < 2) ? 1'b0 : 1'b1);
         rd_chk(IDX_RXBYTE, mt[k]);
         wr(IDX_STAT, 8'h14);
      end
      // Destuffer on, then off
      wr(IDX_CTRL, 8'h01);
      rx_seq(16'h00be, 9);
      rd_chk(IDX_RXBYTE, 8'h7e);
      rx_seq(16'h003f, 8);
      rd_chk(IDX_RXBYTE, 8'h3f);
      wr(IDX_CTRL, 8'h00);
      rx_seq(16'h00be, 8);
      rd_chk(IDX_RXBYTE, 8'hbe);
      // Framing signal bits as source
      wr(IDX_CTRL, 8'h03);
      fs_sel = 1'b1;
      rx_seq(16'h005a, 8);
      rd_chk(IDX_RXBYTE, 8'h5a);
      end_of_test();
   end
endmodule : fdl_link_top_test
